// file: verilog/rsc_defs.svh
// Constants for the reference and temperature sensor control block.
`ifndef RSC_DEFS_SVH
`define RSC_DEFS_SVH

// ********************************************************************
// Register map (byte addresses)
// ********************************************************************
`define RSC_ADDR_W          4
`define RSC_OFF_CTRL        4'h0
`define RSC_OFF_SETTLE      4'h4

// ********************************************************************
// Control register fields
// ********************************************************************
`define RSC_BIT_REF_EN      7
`define RSC_BIT_REF_RDY     6
`define RSC_BIT_TS_EN       5
`define RSC_BIT_TS_RNG      4
`define RSC_GAIN_HI         1
`define RSC_GAIN_LO         0
`define RSC_CTRL_RESET      8'h00
`define RSC_CTRL_WMASK      8'hB3

// ********************************************************************
// Gain codes and timing
// ********************************************************************
`define RSC_GAIN_OFF        2'h0
`define RSC_GAIN_X1         2'h1
`define RSC_GAIN_X2         2'h2
`define RSC_CLK_MHZ         40
`define RSC_SETTLE_US       25
`define RSC_SETTLE_CYC      (`RSC_SETTLE_US * `RSC_CLK_MHZ)
`define RSC_CNT_W           16

// ********************************************************************
// Bus responses
// ********************************************************************
`define RSC_RESP_OKAY       2'h0
`define RSC_RESP_SLVERR     2'h2

`endif

// file: verilog/rsc_pkg.sv
// Types shared by the reference and temperature sensor control block.
package rsc_pkg;
    typedef enum logic [1:0] {
        RSC_REF_OFF    = 2'b00,
        RSC_REF_SETTLE = 2'b01,
        RSC_REF_READY  = 2'b10
    } rsc_ref_state_t;
    typedef logic [1:0] rsc_gain_t;
endpackage

// file: verilog/rsc_settle_timer.sv
// Settling timer that flags when a reference has been enabled long enough.
`timescale 1ns/1ps
`default_nettype none
`include "rsc_defs.svh"
module rsc_settle_timer (
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    input  wire logic                   enable,
    input  wire logic [`RSC_CNT_W-1:0]  limit,
    output logic                        done
);
    import rsc_pkg::*;

    logic [`RSC_CNT_W-1:0] count_q;

    // Counts while enabled, restarts from zero whenever enable drops.
    always_ff @(posedge aclk) begin
        if (!aresetn || !enable) begin
            count_q <= '0;
        end else if (count_q < limit) begin
            count_q <= count_q + `RSC_CNT_W'(1);
        end
    end

    // Done once the count has reached the limit while still enabled.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            done <= 1'b0;
        end else begin
            done <= enable && (count_q >= limit);
        end
    end
endmodule // rsc_settle_timer
`default_nettype wire

// file: verilog/rsc_reference_control.sv
// Reference and temperature sensor control register with AXI4-Lite access.
//
// Local design decisions: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "rsc_defs.svh"
module rsc_reference_control (
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    input  wire logic [31:0]            s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    input  wire logic [31:0]            s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    output logic                        reference_enable,
    output logic                        temp_sense_enable,
    output logic                        temp_range_select,
    output logic                        temp_to_adc_channel,
    output logic                        adc_ref_path_enable,
    output logic                        adc_ref_gain_x2,
    output logic                        reference_ready
);
    import rsc_pkg::*;

    // ****************************************************************
    // Write channel
    // ****************************************************************
    logic                     aw_held_q;
    logic [`RSC_ADDR_W-1:0]   aw_addr_q;
    logic                     w_held_q;
    logic [7:0]               w_data_q;
    logic                     w_strb_q;
    logic [7:0]               ctrl_q;
    logic [`RSC_CNT_W-1:0]    settle_q;
    logic                     do_write;
    logic                     settled;
    rsc_ref_state_t           ref_state_q;

    // Address and data are accepted independently, one write at a time.
    // A channel is refused while its beat is held waiting for the other one, or
    // while the response is still pending, so no beat can be overwritten.
    // The write itself happens in the cycle in which both beats are held.
    assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_held_q && !s_axi_bvalid;
    assign do_write      = aw_held_q && w_held_q && !s_axi_bvalid;

    // Capture the write address and data as each handshake completes.
    // Only the low data byte and its strobe are kept; the upper lanes carry nothing.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            aw_addr_q <= '0;
            w_held_q  <= 1'b0;
            w_data_q  <= 8'h00;
            w_strb_q  <= 1'b0;
        end else if (do_write) begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr[`RSC_ADDR_W-1:0];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                w_data_q <= s_axi_wdata[7:0];
                w_strb_q <= s_axi_wstrb[0];
            end
        end
    end

    // ****************************************************************
    // Write response
    // ****************************************************************
    // Write response; unmapped addresses answer with a slave error.
    // The response stands until the master shows bready, and no new beat is
    // taken meanwhile, so the next write cannot start before it is gone.
    // A write to an unmapped address changes no register.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `RSC_RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            if (aw_addr_q == `RSC_OFF_CTRL || aw_addr_q == `RSC_OFF_SETTLE) begin
                s_axi_bresp <= `RSC_RESP_OKAY;
            end else begin
                s_axi_bresp <= `RSC_RESP_SLVERR;
            end
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    // Control register; only implemented writable bits are stored.
    // Bit 6 is the live ready flag and bits 3 and 2 do not exist, so the mask
    // drops them; bits 3 and 2 always read back as zero.
    // With the low byte lane switched off the register keeps its value.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= `RSC_CTRL_RESET;
        end else if (do_write && w_strb_q && aw_addr_q == `RSC_OFF_CTRL) begin
            ctrl_q <= w_data_q & `RSC_CTRL_WMASK;
        end
    end

    // Settling time in clock cycles, adjustable by software.
    // Only the low byte is loaded: the upper byte is cleared, so a short wait
    // can be set for fast tests and a reset restores the full one.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            settle_q <= `RSC_CNT_W'(`RSC_SETTLE_CYC);
        end else if (do_write && aw_addr_q == `RSC_OFF_SETTLE) begin
            settle_q <= {8'h00, w_data_q};
        end
    end

    // ****************************************************************
    // Reference readiness
    // ****************************************************************
    // The timer restarts whenever the reference is switched off, so a short
    // off pulse always costs a full settling wait before ready returns.
    rsc_settle_timer u_settle (
        .aclk    (aclk),
        .aresetn (aresetn),
        .enable  (ctrl_q[`RSC_BIT_REF_EN]),
        .limit   (settle_q),
        .done    (settled)
    );

    // Ready tracks the enable and the settling wait.
    // Ready falls one cycle after the enable is cleared and rises only after a
    // fresh wait; an unused state code falls back to off rather than hanging.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ref_state_q <= RSC_REF_OFF;
        end else begin
            case (ref_state_q)
                RSC_REF_OFF: begin
                    if (ctrl_q[`RSC_BIT_REF_EN]) ref_state_q <= RSC_REF_SETTLE;
                end
                RSC_REF_SETTLE: begin
                    if (!ctrl_q[`RSC_BIT_REF_EN]) ref_state_q <= RSC_REF_OFF;
                    else if (settled) ref_state_q <= RSC_REF_READY;
                end
                RSC_REF_READY: begin
                    if (!ctrl_q[`RSC_BIT_REF_EN]) ref_state_q <= RSC_REF_OFF;
                end
                default: ref_state_q <= RSC_REF_OFF;
            endcase
        end
    end

    // ****************************************************************
    // Analog controls
    // ****************************************************************
    // Analog control outputs.
    // Each control except reference_ready follows its register bits directly, so the analog side sees a
    // change in the cycle after the write; the reserved gain code acts as 2x.
    assign reference_enable    = ctrl_q[`RSC_BIT_REF_EN];
    assign reference_ready     = (ref_state_q == RSC_REF_READY);
    assign temp_sense_enable   = ctrl_q[`RSC_BIT_TS_EN];
    assign temp_range_select   = ctrl_q[`RSC_BIT_TS_RNG];
    assign temp_to_adc_channel = ctrl_q[`RSC_BIT_TS_EN];
    assign adc_ref_path_enable = ctrl_q[`RSC_GAIN_HI:`RSC_GAIN_LO] != `RSC_GAIN_OFF;
    assign adc_ref_gain_x2     = ctrl_q[`RSC_GAIN_HI];

    // ****************************************************************
    // Read channel
    // ****************************************************************
    // The read address is refused while read data wait to be taken, which
    // keeps one read in flight; reads may overlap a write.
    assign s_axi_arready = !s_axi_rvalid;

    // Read data; ready bit reflects live state, unused bits read zero.
    // An unmapped address returns zero data with a slave error.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `RSC_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `RSC_RESP_OKAY;
            if (s_axi_araddr[`RSC_ADDR_W-1:0] == `RSC_OFF_CTRL) begin
                s_axi_rdata <= {24'h000000, ctrl_q[7], reference_ready, ctrl_q[5:0]};
            end else if (s_axi_araddr[`RSC_ADDR_W-1:0] == `RSC_OFF_SETTLE) begin
                s_axi_rdata <= {16'h0000, settle_q};
            end else begin
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= `RSC_RESP_SLVERR;
            end
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule // rsc_reference_control
`default_nettype wire

// file: sim/rsc_chk.sv
// Port assertions for the reference and sensor control block.
`timescale 1ns/1ps
`default_nettype none
`include "rsc_defs.svh"
module rsc_chk (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        reference_enable,
    input wire logic        temp_sense_enable,
    input wire logic        temp_to_adc_channel,
    input wire logic        adc_ref_path_enable,
    input wire logic        adc_ref_gain_x2,
    input wire logic        reference_ready
);
    // All checks run on the bus clock and pause in reset.
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    chk_ts_route: assert property (temp_to_adc_channel == temp_sense_enable)
        else $error("sensor channel differs from its enable");
    chk_gain_path: assert property (adc_ref_gain_x2 |-> adc_ref_path_enable)
        else $error("double gain without reference path");
    chk_rdy_drop: assert property (!reference_enable |=> !reference_ready)
        else $error("ready stays up with reference off");
    chk_rdy_wait: assert property ($rose(reference_ready) |-> $past(reference_enable, 2))
        else $error("ready rose too early");
    chk_reset_outs: assert property ($rose(aresetn) |->
        !(reference_enable | temp_sense_enable | adc_ref_path_enable | reference_ready))
        else $error("output high after reset");
    chk_b_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write response late");
    chk_r_answer: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid && !s_axi_arready)
        else $error("read answer late");
    chk_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("write address taken during response");
    cover property ($rose(reference_ready));
    cover property (s_axi_rvalid && s_axi_rready);
    cover property (s_axi_bvalid && s_axi_bresp == `RSC_RESP_SLVERR);
endmodule // rsc_chk
bind rsc_reference_control rsc_chk i_rsc_chk (.*);
`default_nettype wire

// file: sim/rsc_analog_model.sv
// Behavioural model of the reference amplifier and sensor circuits.
`timescale 1ns/1ps
`default_nettype none
module rsc_analog_model (
    input wire logic        aclk,
    input wire logic        conv_start,
    input wire logic        temp_sense_enable,
    input wire logic        temp_range_select,
    input wire logic        temp_to_adc_channel,
    input wire logic        adc_ref_path_enable,
    input wire logic        adc_ref_gain_x2,
    output logic [11:0]     ref_mv,
    output logic [2:0]      ts_drop,
    output logic            conv_ok
);
    // Acquisition wait on the sensor channel: 200 us of 25 ns cycles.
    localparam logic [13:0] ACQ_CYC = 14'h1F40;
    logic [13:0]            wait_q;
    // Reference level in millivolts at the converter.
    assign ref_mv = adc_ref_path_enable ? (adc_ref_gain_x2 ? 12'h800 : 12'h400) : 12'h000;
    // Junction drops seen on the sensor channel, none when unpowered.
    assign ts_drop = (temp_sense_enable && temp_to_adc_channel) ?
        (temp_range_select ? 3'h4 : 3'h2) : 3'h0;
    // Counts cycles since the sensor channel came up or the last conversion began.
    always_ff @(posedge aclk) begin
        if (!(temp_sense_enable && temp_to_adc_channel) || conv_start) begin
            wait_q <= 14'h0000;
        end else if (wait_q != 14'h3FFF) begin
            wait_q <= wait_q + 14'h0001;
        end
    end
    // A conversion started now would see a settled sensor voltage.
    assign conv_ok = (wait_q >= ACQ_CYC);
endmodule // rsc_analog_model
`default_nettype wire

// file: sim/tb_top.sv
// Self-checking bench for the reference and sensor control block.
`timescale 1ns/1ps
`default_nettype none
`include "rsc_defs.svh"
module tb_top;
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rv;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic reference_enable, temp_sense_enable, temp_range_select, temp_to_adc_channel;
    logic adc_ref_path_enable, adc_ref_gain_x2, reference_ready;
    logic [11:0] ref_mv;
    logic [2:0] ts_drop;
    logic conv_start, conv_ok;
    localparam int ACQ_CYC = 8000;
    logic [7:0] d;
    int n_errors, n_compared, seed, i;
    rsc_reference_control i_rsc_reference_control (.*);
    rsc_analog_model i_rsc_analog_model (.*);
    // Free-running bus clock.
    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end
    // Prints the counts and the verdict, then ends the run.
    task stop_test;
        $display("Compared %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Compares a seen value with the expected one.
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Ends the run when a bounded wait ran out.
    task tmo(input int k);
        if (k >= 60) begin
            n_errors++;
            stop_test;
        end
    endtask
    // One write; each channel is released at the edge that takes it.
    task wr(input logic [31:0] a, input logic [31:0] v, output logic [1:0] r);
        int k;
        logic pa, pw, ta, tw;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        pa = 1'b1;
        pw = 1'b1;
        for (k = 0; k < 60 && (pa || pw); k++) begin
            @(negedge aclk);
            ta = s_axi_awready & pa;
            tw = s_axi_wready & pw;
            @(posedge aclk);
            if (ta) begin
                s_axi_awvalid <= 1'b0;
                pa = 1'b0;
            end
            if (tw) begin
                s_axi_wvalid <= 1'b0;
                pw = 1'b0;
            end
        end
        tmo(k);
        for (k = 0; k < 60 && s_axi_bvalid !== 1'b1; k++) @(negedge aclk);
        tmo(k);
        r = s_axi_bresp;
        @(posedge aclk);
        s_axi_bready <= 1'b0;
    endtask
    // One read; address is held until the edge that takes it.
    task rd(input logic [31:0] a, output logic [31:0] v, output logic [1:0] r);
        int k;
        logic ta;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        ta = 1'b0;
        for (k = 0; k < 60 && !ta; k++) begin
            @(negedge aclk);
            ta = s_axi_arready;
            @(posedge aclk);
            if (ta) s_axi_arvalid <= 1'b0;
        end
        tmo(k);
        for (k = 0; k < 60 && s_axi_rvalid !== 1'b1; k++) @(negedge aclk);
        tmo(k);
        v = s_axi_rdata;
        r = s_axi_rresp;
        @(posedge aclk);
        s_axi_rready <= 1'b0;
    endtask
    // Expected control outputs and analog levels for a control byte.
    function automatic logic [20:0] exp_out(input logic [7:0] c);
        logic [11:0] mv;
        logic [2:0] dr;
        mv = (c[1:0] == 2'h0) ? 12'h000 : (c[1] ? 12'h800 : 12'h400);
        dr = c[5] ? (c[4] ? 3'h4 : 3'h2) : 3'h0;
        return {c[7], c[5], c[4], c[5], |c[1:0], c[1], mv, dr};
    endfunction
    // Main sequence: reset, random control bytes, settling, bad addresses.
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
        s_axi_wstrb = 4'hF;
        conv_start = 1'b0;
        seed = 32'h9dc2;
        n_errors = 0;
        n_compared = 0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`RSC_OFF_CTRL, rv, rr);
        chk(rv, `RSC_CTRL_RESET);
        wr(`RSC_OFF_SETTLE, 32'h4, rr);
        chk(rr, `RSC_RESP_OKAY);
        rd(`RSC_OFF_SETTLE, rv, rr);
        chk(rv, 32'h4);
        for (i = 0; i < 16; i++) begin
            d = (i == 0) ? 8'hFF : 8'($random(seed));
            wr(`RSC_OFF_CTRL, {24'h0, d}, rr);
            @(negedge aclk);
            chk({reference_enable, temp_sense_enable, temp_range_select, temp_to_adc_channel,
                adc_ref_path_enable, adc_ref_gain_x2, ref_mv, ts_drop}, exp_out(d));
            rd(`RSC_OFF_CTRL, rv, rr);
            chk(rv & 32'hFFFFFFBF, d & `RSC_CTRL_WMASK);
        end
        wr(`RSC_OFF_CTRL, 32'h4C, rr);
        rd(`RSC_OFF_CTRL, rv, rr);
        chk(rv, 32'h0);
        wr(`RSC_OFF_CTRL, 32'h80, rr);
        @(negedge aclk);
        chk(reference_ready, 1'b0);
        for (i = 0; i < 60 && reference_ready !== 1'b1; i++) @(negedge aclk);
        tmo(i);
        wr(`RSC_OFF_CTRL, 32'hB3, rr);
        rd(`RSC_OFF_CTRL, rv, rr);
        chk(rv, 32'hF3);
        s_axi_wstrb <= 4'h0;
        wr(`RSC_OFF_CTRL, 32'h00, rr);
        s_axi_wstrb <= 4'hF;
        rd(`RSC_OFF_CTRL, rv, rr);
        chk(rv, 32'hF3);
        wr(`RSC_OFF_CTRL, 32'h00, rr);
        wr(`RSC_OFF_CTRL, 32'h20, rr);
        @(negedge aclk);
        chk(conv_ok, 1'b0);
        repeat (ACQ_CYC) @(posedge aclk);
        @(negedge aclk);
        chk(conv_ok, 1'b1);
        @(posedge aclk);
        conv_start <= 1'b1;
        @(posedge aclk);
        conv_start <= 1'b0;
        @(negedge aclk);
        chk(conv_ok, 1'b0);
        repeat (ACQ_CYC) @(posedge aclk);
        @(negedge aclk);
        chk(conv_ok, 1'b1);
        rd(32'h8, rv, rr);
        chk(rv, 32'h0);
        chk(rr, `RSC_RESP_SLVERR);
        wr(32'hC, 32'h0, rr);
        chk(rr, `RSC_RESP_SLVERR);
        stop_test;
    end
endmodule // tb_top
`default_nettype wire
